//--- design/cmc_top.sv
// control wrapper around the analog voltage comparator
`timescale 1ns/10ps
module cmc_top
  import cmc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // peripheral bus slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog comparator core
  input  wire logic        comp_raw_i,
  output logic             comp_power_o,
  output logic      [1:0]  neg_sel_o,
  output logic             speed_fast_o,
  output logic             hyst_en_o,
  // result consumers
  output logic             pin_out_o,
  output logic             pin_out_en_o,
  output logic             irq_o,
  output logic             pla_o,
  output logic             adc_start_o
);

  // bus phase and decode
  cmc_phase_t             phase;
  cmc_phase_t             next_phase;
  logic                   addr_hit;
  logic                   wr_access;
  logic                   rd_setup;
  logic                   acc_cycle;
  logic [31:0]            next_prdata;

  // control register fields
  logic                   comp_en;
  logic [1:0]             neg_sel;
  logic [1:0]             route_sel;
  logic                   polarity;
  logic [1:0]             speed_sel;
  logic                   hyst_sel;

  // decoded selections
  logic                   route_pin;
  logic                   route_irq;
  logic                   speed_fast;

  // comparator result path
  logic                   comp_sync;
  logic                   comp_out;
  logic                   comp_prev;
  logic                   prev_valid;
  logic                   rise_evt;
  logic                   fall_evt;

  // event flags
  logic [CMC_NUM_FLAGS-1:0] flag_set;
  logic [CMC_NUM_FLAGS-1:0] flag_clr;
  logic [CMC_NUM_FLAGS-1:0] flags;

  // read view
  logic [CMC_REG_W-1:0]   ctrl_view;

  assign addr_hit  = (paddr_i == CMC_CTRL_ADDR);
  assign acc_cycle = psel_i && penable_i;
  assign wr_access = acc_cycle && pwrite_i && addr_hit && (phase == CMC_PH_ACCESS);
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;

  // setup then access, always ready in the access cycle
  always_comb begin
    next_phase = phase;
    case (phase)
      CMC_PH_IDLE: begin
        if (psel_i && !penable_i) begin
          next_phase = CMC_PH_ACCESS;
        end
      end
      CMC_PH_ACCESS: begin
        if (psel_i && !penable_i) begin
          next_phase = CMC_PH_ACCESS;
        end else begin
          next_phase = CMC_PH_IDLE;
        end
      end
      default: begin
        next_phase = CMC_PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= CMC_PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // no wait states: the access cycle is the second and last
  assign pready_o = 1'b1;

  // unmapped addresses report an error in the access cycle
  assign pslverr_o = acc_cycle && !addr_hit;

  // configuration fields, written in the access cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comp_en <= CMC_CTRL_RESET[CMC_EN_BIT];
    end else if (wr_access) begin
      comp_en <= pwdata_i[CMC_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      neg_sel <= CMC_CTRL_RESET[CMC_NSEL_HI:CMC_NSEL_LO];
    end else if (wr_access) begin
      neg_sel <= pwdata_i[CMC_NSEL_HI:CMC_NSEL_LO];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_sel <= CMC_CTRL_RESET[CMC_ROUTE_HI:CMC_ROUTE_LO];
    end else if (wr_access) begin
      route_sel <= pwdata_i[CMC_ROUTE_HI:CMC_ROUTE_LO];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      polarity <= CMC_CTRL_RESET[CMC_POL_BIT];
    end else if (wr_access) begin
      polarity <= pwdata_i[CMC_POL_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_sel <= CMC_CTRL_RESET[CMC_SPEED_HI:CMC_SPEED_LO];
    end else if (wr_access) begin
      speed_sel <= pwdata_i[CMC_SPEED_HI:CMC_SPEED_LO];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hyst_sel <= CMC_CTRL_RESET[CMC_HYST_BIT];
    end else if (wr_access) begin
      hyst_sel <= pwdata_i[CMC_HYST_BIT];
    end
  end

  // register image; reserved bits read as zero
  always_comb begin
    ctrl_view                            = CMC_CTRL_RESET;
    ctrl_view[CMC_EN_BIT]                = comp_en;
    ctrl_view[CMC_NSEL_HI:CMC_NSEL_LO]   = neg_sel;
    ctrl_view[CMC_ROUTE_HI:CMC_ROUTE_LO] = route_sel;
    ctrl_view[CMC_POL_BIT]               = polarity;
    ctrl_view[CMC_SPEED_HI:CMC_SPEED_LO] = speed_sel;
    ctrl_view[CMC_HYST_BIT]              = hyst_sel;
    ctrl_view[CMC_RISE_BIT]              = flags[CMC_RISE_BIT];
    ctrl_view[CMC_FALL_BIT]              = flags[CMC_FALL_BIT];
  end

  // read image of the addressed register; unmapped reads give zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_hit) begin
      next_prdata = {16'h0000, ctrl_view};
    end
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= next_prdata;
    end
  end

  // reserved route codes select neither output; reserved speed codes give normal speed
  assign route_pin  = comp_en && (route_sel == CMC_ROUTE_PIN);
  assign route_irq  = (route_sel == CMC_ROUTE_IRQ);
  assign speed_fast = comp_en && (speed_sel == CMC_SPEED_FAST);

  // analog controls; power follows the enable bit
  assign comp_power_o = comp_en;
  assign neg_sel_o    = comp_en ? neg_sel : CMC_NSEL_HALF;
  assign speed_fast_o = speed_fast;
  assign hyst_en_o    = comp_en && hyst_sel;

  // raw result crosses into the clock domain first
  cmc_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .async_i(comp_raw_i),
    .sync_o (comp_sync)
  );

  // polarity and enable gating of the result
  assign comp_out = comp_en && (comp_sync ^ polarity);

  // previous sample; the first sample after enabling only primes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comp_prev <= 1'b0;
    end else begin
      comp_prev <= comp_out;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_valid <= 1'b0;
    end else begin
      prev_valid <= comp_en;
    end
  end

  assign rise_evt = comp_en && prev_valid && comp_out && !comp_prev;
  assign fall_evt = comp_en && prev_valid && !comp_out && comp_prev;

  assign flag_set[CMC_RISE_BIT] = rise_evt;
  assign flag_set[CMC_FALL_BIT] = fall_evt;

  // sticky flags, each cleared by writing one to its bit
  generate
    for (genvar i = 0; i < CMC_NUM_FLAGS; i++) begin : g_flag
      assign flag_clr[i] = wr_access && pwdata_i[i];
      cmc_flag u_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (flag_set[i]),
        .clear_i(flag_clr[i]),
        .flag_o (flags[i])
      );
    end
  endgenerate

  // result consumers, registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_en_o <= 1'b0;
    end else begin
      pin_out_en_o <= route_pin;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0;
    end else begin
      pin_out_o <= route_pin && comp_out;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= route_irq && (|flags);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pla_o <= 1'b0;
    end else begin
      pla_o <= comp_out;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_start_o <= 1'b0;
    end else begin
      adc_start_o <= rise_evt;
    end
  end

endmodule

//--- design/cmc_pkg.sv
// constants and types shared by the comparator control block
package cmc_pkg;

  // register map and bus
  localparam logic [31:0] CMC_CTRL_ADDR    = 32'hFFFF0444;
  localparam int          CMC_REG_W        = 16;
  localparam logic [15:0] CMC_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CMC_CFG_MASK     = 16'h07FC;

  // field positions
  localparam int          CMC_EN_BIT       = 10;
  localparam int          CMC_NSEL_HI      = 9;
  localparam int          CMC_NSEL_LO      = 8;
  localparam int          CMC_ROUTE_HI     = 7;
  localparam int          CMC_ROUTE_LO     = 6;
  localparam int          CMC_POL_BIT      = 5;
  localparam int          CMC_SPEED_HI     = 4;
  localparam int          CMC_SPEED_LO     = 3;
  localparam int          CMC_HYST_BIT     = 2;
  localparam int          CMC_RISE_BIT     = 1;
  localparam int          CMC_FALL_BIT     = 0;
  localparam int          CMC_NUM_FLAGS    = 2;

  // negative input selection codes
  localparam logic [1:0]  CMC_NSEL_HALF    = 2'h0;
  localparam logic [1:0]  CMC_NSEL_ADC_CHANNEL_THREE    = 2'h1;
  localparam logic [1:0]  CMC_NSEL_DAC     = 2'h2;

  // output routing codes
  localparam logic [1:0]  CMC_ROUTE_PIN    = 2'h2;
  localparam logic [1:0]  CMC_ROUTE_IRQ    = 2'h3;

  // response speed codes
  localparam logic [1:0]  CMC_SPEED_NORM   = 2'h0;
  localparam logic [1:0]  CMC_SPEED_FAST   = 2'h3;

  // bus phase of the peripheral bus slave
  typedef enum logic [1:0] {
    CMC_PH_IDLE   = 2'b01,
    CMC_PH_ACCESS = 2'b10
  } cmc_phase_t;

endpackage

//--- design/cmc_sync.sv
// two flip-flop synchroniser for the asynchronous comparator result
`timescale 1ns/10ps
module cmc_sync
  import cmc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // data
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

//--- design/cmc_flag.sv
// sticky event flag, set by hardware and cleared by writing one
`timescale 1ns/10ps
module cmc_flag
  import cmc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic set_i,
  input  wire logic clear_i,
  // state
  output logic      flag_o
);

  // a set in the clearing cycle wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clear_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule

//--- tb/cmc_top_sva.sv
// assertion checker for the comparator control block
`timescale 1ns/10ps
module cmc_top_sva
  import cmc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        comp_power_o,
  input wire logic [1:0]  neg_sel_o,
  input wire logic        speed_fast_o,
  input wire logic        hyst_en_o,
  input wire logic        pin_out_o,
  input wire logic        pin_out_en_o,
  input wire logic        irq_o,
  input wire logic        adc_start_o
);
  logic hit;
  assign hit = psel_i && penable_i && pwrite_i && (paddr_i == CMC_CTRL_ADDR);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_ready_a: assert property (pready_o)
    else $error("ready low");
  addr_err_a: assert property (psel_i && penable_i |-> pslverr_o == (paddr_i != CMC_CTRL_ADDR))
    else $error("error flag wrong");
  rd_upper_a: assert property (prdata_o[31:11] == 21'h0)
    else $error("upper read bits set");
  en_write_a: assert property (hit |=> comp_power_o == $past(pwdata_i[CMC_EN_BIT]))
    else $error("power not from enable");
  off_quiet_a: assert property (!comp_power_o |-> neg_sel_o == 2'h0 && !speed_fast_o && !hyst_en_o)
    else $error("core active while off");
  cfg_write_a: assert property (hit && pwdata_i[10] |=> neg_sel_o == $past(pwdata_i[9:8])
    && hyst_en_o == $past(pwdata_i[2]) && speed_fast_o == ($past(pwdata_i[4:3]) == CMC_SPEED_FAST))
    else $error("core config mismatch");
  route_excl_a: assert property (pin_out_en_o |-> !irq_o)
    else $error("pin and irq both routed");
  pin_gate_a: assert property (pin_out_o |-> pin_out_en_o)
    else $error("pin driven while not routed");
  adc_pulse_a: assert property (adc_start_o |=> !adc_start_o)
    else $error("adc start too long");
endmodule
bind cmc_top cmc_top_sva cmc_top_sva_inst (.*);

//--- tb/cmc_core_model.sv
// behavioural analog comparator core with its input multiplexer
`timescale 1ns/10ps
module cmc_core_model
  import cmc_pkg::*;
#(parameter real AVDD_MV = 3300.0)
(
  input wire logic       clk_i,
  input wire logic       comp_power_i,
  input wire logic [1:0] neg_sel_i,
  input wire logic       speed_fast_i,
  input wire logic       hyst_en_i,
  input var  real        pos_mv_i,
  input var  real        adc_channel_three_mv_i,
  input var  real        dac_mv_i,
  output logic           comp_raw_o
);
  real  neg_mv;
  logic cmp;
  logic slow_q;
  initial comp_raw_o = 1'b0;
  always_comb begin
    case (neg_sel_i)
      CMC_NSEL_ADC_CHANNEL_THREE: neg_mv = adc_channel_three_mv_i;
      CMC_NSEL_DAC:  neg_mv = dac_mv_i;
      default:       neg_mv = AVDD_MV / 2.0;
    endcase
    cmp = pos_mv_i > neg_mv + (hyst_en_i ? (comp_raw_o ? -7.5 : 7.5) : 0.0);
  end
  // unpowered core gives noise, slow mode lags one more cycle
  always @(posedge clk_i) begin
    slow_q <= cmp;
    if (!comp_power_i) comp_raw_o <= ~comp_raw_o;
    else if (speed_fast_i) comp_raw_o <= cmp;
    else comp_raw_o <= slow_q;
  end
endmodule

//--- tb/cmc_top_tb.sv
// self-checking testbench of the comparator control block
`timescale 1ns/10ps
module cmc_top_tb;
  import cmc_pkg::*;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, rd_q;
  logic        pready_o, pslverr_o, comp_raw_i, comp_power_o, speed_fast_o, hyst_en_o;
  logic        pin_out_o, pin_out_en_o, irq_o, pla_o, adc_start_o;
  logic [1:0]  neg_sel_o;
  real         pos_mv, adc_channel_three_mv, dac_mv;
  int          failures, tests_run, adc_cnt;
  cmc_top cmc_top_inst (.*);
  cmc_core_model cmc_core_model_inst (.clk_i(clk_i), .comp_power_i(comp_power_o),
    .neg_sel_i(neg_sel_o), .speed_fast_i(speed_fast_o), .hyst_en_i(hyst_en_o),
    .pos_mv_i(pos_mv), .adc_channel_three_mv_i(adc_channel_three_mv), .dac_mv_i(dac_mv), .comp_raw_o(comp_raw_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (adc_start_o) adc_cnt++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    rd_q = prdata_o;
    chk({30'h0, pready_o, pslverr_o}, {30'h0, 1'b1, a != CMC_CTRL_ADDR});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task drive_pos(input real p);
    @(posedge clk_i);
    pos_mv <= p;
    repeat (10) @(posedge clk_i);
  endtask
  task t_regs;
    rd(CMC_CTRL_ADDR, 32'h0);
    bus(1'b1, CMC_CTRL_ADDR, 32'hFFFFFFDC);
    // stale samples of the powering core may set flags; let them pass first
    drive_pos(0.0);
    bus(1'b1, CMC_CTRL_ADDR, 32'hFFFFFFDF);
    rd(CMC_CTRL_ADDR, 32'h07DC);
    chk({27'h0, comp_power_o, neg_sel_o, speed_fast_o, hyst_en_o}, 32'h1F);
    bus(1'b1, 32'hFFFF0448, 32'h0);
    rd(32'hFFFF0448, 32'h0);
    bus(1'b1, CMC_CTRL_ADDR, 32'h0408);
    rd(CMC_CTRL_ADDR, 32'h0408);
    chk({31'h0, speed_fast_o}, 32'h0);
  endtask
  task t_edges;
    int n;
    bus(1'b1, CMC_CTRL_ADDR, 32'h04D8);
    n = adc_cnt;
    drive_pos(3000.0);
    chk(adc_cnt - n, 32'h1);
    rd(CMC_CTRL_ADDR, 32'h04DA);
    chk({31'h0, irq_o}, 32'h1);
    drive_pos(0.0);
    chk(adc_cnt - n, 32'h1);
    rd(CMC_CTRL_ADDR, 32'h04DB);
    bus(1'b1, CMC_CTRL_ADDR, 32'h04D9);
    rd(CMC_CTRL_ADDR, 32'h04DA);
    bus(1'b1, CMC_CTRL_ADDR, 32'h04D8);
    rd(CMC_CTRL_ADDR, 32'h04DA);
    chk({31'h0, irq_o}, 32'h1);
    bus(1'b1, CMC_CTRL_ADDR, 32'h04DA);
    rd(CMC_CTRL_ADDR, 32'h04D8);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task t_route;
    bus(1'b1, CMC_CTRL_ADDR, 32'h04A0);
    drive_pos(3000.0);
    chk({28'h0, irq_o, pin_out_en_o, pin_out_o, pla_o}, 32'h4);
    drive_pos(0.0);
    chk({28'h0, irq_o, pin_out_en_o, pin_out_o, pla_o}, 32'h7);
    bus(1'b1, CMC_CTRL_ADDR, 32'h0420);
    drive_pos(0.0);
    chk({28'h0, irq_o, pin_out_en_o, pin_out_o, pla_o}, 32'h1);
  endtask
  task t_sel;
    logic [2:0] exp;
    exp = 3'b010;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, CMC_CTRL_ADDR, 32'h0400 | (i << 8));
      drive_pos(1000.0);
      chk({31'h0, pla_o}, {31'h0, exp[i]});
    end
  endtask
  task t_off;
    bus(1'b1, CMC_CTRL_ADDR, 32'h0003);
    drive_pos(3000.0);
    drive_pos(0.0);
    rd(CMC_CTRL_ADDR, 32'h0);
    chk({30'h0, comp_power_o, pla_o}, 32'h0);
  endtask
  task final_report;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 32'h0;
    pwdata_i = 32'h0;
    pos_mv = 0.0;
    adc_channel_three_mv = 500.0;
    dac_mv = 2500.0;
    failures = 0;
    tests_run = 0;
    adc_cnt = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_edges;
    t_route;
    t_sel;
    t_off;
    final_report;
  end
  initial begin
    #50000;
    failures++;
    final_report;
  end
endmodule
